// ---- rtl/pst_pkg.sv ----
// Shared constants and types for the power state and thermal trip controller
package pst_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PST_RUN,
    PST_SAVE,
    PST_MGMT_ACK,
    PST_STOP_ACK,
    PST_STOP,
    PST_SLEEP,
    PST_RESUME
  } pst_state_e;

  // ----------------------------------------------------------------
  // Special bus transaction codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PST_TXN_NONE = 2'h0;
  localparam logic [1:0] PST_TXN_MGMT_ACK = 2'h1;
  localparam logic [1:0] PST_TXN_STOP_ACK = 2'h2;

  // ----------------------------------------------------------------
  // Synchroniser groups and bit positions
  // ----------------------------------------------------------------
  localparam int PST_REQ_W = 3;
  localparam int PST_REQ_MGMT = 0;
  localparam int PST_REQ_HALT = 1;
  localparam int PST_REQ_SLEEP = 2;
  localparam int PST_LVL_W = 3;
  localparam int PST_LVL_HOT = 0;
  localparam int PST_LVL_CORE = 1;
  localparam int PST_LVL_TERM = 2;

  // Idle levels loaded into the synchronisers at reset
  localparam logic PST_REQ_IDLE = 1'b1;
  localparam logic PST_LVL_IDLE = 1'b0;

endpackage

// ---- rtl/pst_sync.sv ----
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module pst_sync #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Asynchronous levels and their synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } pst_sync_s;

  pst_sync_s sync_r;
  pst_sync_s sync_nxt;

  // First stage feeds only the second stage
  always_comb begin
    sync_nxt.meta = async_in;
    sync_nxt.safe = sync_r.meta;
  end

  // Both stages load the idle level at reset
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_r <= {(2 * WIDTH){RESET_VAL}};
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r.safe;

endmodule

// ---- rtl/pst_ctrl.sv ----
// Power state and over-temperature trip controller
`timescale 1ns/1ps
// Contract
// (R1) Management request saves state, enters management mode
// (R2) Then management acknowledge, then handler fetch
// (R3) Management request is asynchronous, accepted any time; the code ignores it in sleep
// (R4) Clock halt enters stop-grant, issues acknowledge
// (R5) Stop-grant gates core, keeps bus, interrupt unit
// (R6) Stop-grant keeps snooping and latching interrupts
// (R7) Halt release restarts, services pending, resumes
// (R8) Bus clock untouched; halt request is asynchronous
// (R9) Over trip temperature halts and asserts trip
// (R10) Trip latched until reset or power removal
// (R11) Cool at reset clears trip, runs normally
// (R12) Still hot after reset re-asserts trip
// (R13) System cuts both supplies after trip
// (R14) Trip output released once both supplies off
// (R15) System ignores trip release after supply removal
// (R16) Sleep from stop-grant; only sleep, halt, reset
// (R17) Sleep release returns to stop-grant clocks
// (R18) Async requests pass two-stage synchroniser first
module pst_ctrl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Asynchronous system requests, active low
  input wire logic mgmt_irq_req_n_in,
  input wire logic clock_halt_req_n_in,
  input wire logic deep_sleep_req_n_in,
  // Asynchronous sensor and supply levels
  input wire logic temp_over_trip_in,
  input wire logic core_pwr_good_in,
  input wire logic term_pwr_good_in,
  // Core side, same clock
  input wire logic save_done_in,
  input wire logic mgmt_resume_in,
  input wire logic irq_event_in,
  input wire logic special_txn_ack_in,
  // Management mode and execution
  output logic save_state_req_out,
  output logic mgmt_exec_mode_out,
  output logic handler_fetch_out,
  // Special bus transaction request
  output logic special_txn_req_out,
  output logic [1:0] special_txn_type_out,
  // Unit clock enables
  output logic core_clk_en_out,
  output logic bus_unit_clk_en_out,
  output logic local_interrupt_unit_clk_en_out,
  // Snoop and interrupt status
  output logic snoop_en_out,
  output logic irq_pending_out,
  output logic irq_service_out,
  // Thermal protection
  output logic exec_halt_out,
  output logic overtemp_halt_n_out
);
  import pst_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pst_state_e st;
    logic mgmt_mode;
    logic mgmt_pend;
    logic mgmt_req_d;
    logic irq_pend;
    logic trip;
    logic save_req;
    logic txn_req;
    logic [1:0] txn_type;
    logic fetch;
    logic svc;
    logic core_en;
    logic bus_en;
    logic lint_en;
  } pst_ctrl_s;

  pst_ctrl_s ctrl_r;
  pst_ctrl_s ctrl_nxt;

  logic [PST_REQ_W-1:0] req_n_s;
  logic [PST_LVL_W-1:0] lvl_s;
  logic mgmt_req;
  logic halt_req;
  logic sleep_req;
  logic hot;
  logic pwr_any;
  logic mgmt_edge;
  logic mgmt_take;
  logic irq_accept;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Request pins enter only through two flops
  pst_sync #(
    .WIDTH(PST_REQ_W),
    .RESET_VAL(PST_REQ_IDLE)
  ) u_req_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({deep_sleep_req_n_in, clock_halt_req_n_in, mgmt_irq_req_n_in}), // R3 R8 R18
    .sync_out(req_n_s)
  );

  // Sensor and supply levels, same treatment
  pst_sync #(
    .WIDTH(PST_LVL_W),
    .RESET_VAL(PST_LVL_IDLE)
  ) u_lvl_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({term_pwr_good_in, core_pwr_good_in, temp_over_trip_in}), // R18
    .sync_out(lvl_s)
  );

  // Active-high views of the synchronised inputs
  assign mgmt_req = ~req_n_s[PST_REQ_MGMT];
  assign halt_req = ~req_n_s[PST_REQ_HALT];
  assign sleep_req = ~req_n_s[PST_REQ_SLEEP];
  assign hot = lvl_s[PST_LVL_HOT];
  assign pwr_any = lvl_s[PST_LVL_CORE] | lvl_s[PST_LVL_TERM];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt.fetch = 1'b0;
    ctrl_nxt.svc = 1'b0;
    mgmt_take = 1'b0;
    ctrl_nxt.mgmt_req_d = mgmt_req;
    // Rising edge of the active-high mgmt_req, ignored while asleep
    mgmt_edge = mgmt_req & ~ctrl_r.mgmt_req_d & (ctrl_r.st != PST_SLEEP); // R3 R16
    // Interrupts latch everywhere but sleep
    irq_accept = irq_event_in & (ctrl_r.st != PST_SLEEP); // R6 R16
    // Trip latches while any supply is up, drops when both are gone
    ctrl_nxt.trip = (ctrl_r.trip | hot) & pwr_any; // R9 R10 R11 R12 R14
    if (!ctrl_r.trip) begin
      unique case (ctrl_r.st)
        PST_RUN: begin
          if (mgmt_resume_in && ctrl_r.mgmt_mode) begin
            ctrl_nxt.mgmt_mode = 1'b0;
          end
          if (halt_req) begin
            ctrl_nxt.st = PST_STOP_ACK; // R4
            ctrl_nxt.txn_req = 1'b1;
            ctrl_nxt.txn_type = PST_TXN_STOP_ACK;
          end else if (ctrl_r.mgmt_pend && !ctrl_r.mgmt_mode) begin
            ctrl_nxt.st = PST_SAVE; // R1
            ctrl_nxt.save_req = 1'b1;
            mgmt_take = 1'b1;
          end
        end
        PST_SAVE: begin
          if (save_done_in) begin
            ctrl_nxt.save_req = 1'b0;
            ctrl_nxt.mgmt_mode = 1'b1; // R1
            ctrl_nxt.st = PST_MGMT_ACK; // R2
            ctrl_nxt.txn_req = 1'b1;
            ctrl_nxt.txn_type = PST_TXN_MGMT_ACK;
          end
        end
        PST_MGMT_ACK: begin
          if (special_txn_ack_in) begin
            ctrl_nxt.txn_req = 1'b0;
            ctrl_nxt.txn_type = PST_TXN_NONE;
            ctrl_nxt.fetch = 1'b1; // R2
            ctrl_nxt.st = PST_RUN;
          end
        end
        PST_STOP_ACK: begin
          if (special_txn_ack_in) begin
            ctrl_nxt.txn_req = 1'b0;
            ctrl_nxt.txn_type = PST_TXN_NONE;
            ctrl_nxt.st = PST_STOP; // R4
          end
        end
        PST_STOP: begin
          if (sleep_req) begin
            ctrl_nxt.st = PST_SLEEP; // R16
          end else if (!halt_req) begin
            ctrl_nxt.st = PST_RESUME; // R7
          end
        end
        PST_SLEEP: begin
          if (!sleep_req) begin
            ctrl_nxt.st = PST_STOP; // R17
          end
        end
        PST_RESUME: begin
          // Service what was latched, then run again
          ctrl_nxt.svc = ctrl_r.irq_pend; // R7
          ctrl_nxt.st = PST_RUN;
        end
        default: begin
          ctrl_nxt.st = PST_RUN;
        end
      endcase
    end
    // Set wins over clear on both pending flags
    ctrl_nxt.mgmt_pend = (ctrl_r.mgmt_pend & ~mgmt_take) | mgmt_edge;
    ctrl_nxt.irq_pend = (ctrl_r.irq_pend & ~ctrl_nxt.svc) | irq_accept; // R6
    // Clock enables follow the coming state
    ctrl_nxt.core_en = ~ctrl_nxt.trip & (ctrl_nxt.st != PST_STOP_ACK)
      & (ctrl_nxt.st != PST_STOP) & (ctrl_nxt.st != PST_SLEEP); // R5 R7 R9
    ctrl_nxt.bus_en = ctrl_nxt.st != PST_SLEEP; // R5 R8 R16 R17
    ctrl_nxt.lint_en = ctrl_nxt.st != PST_SLEEP; // R5 R16 R17
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= '{st: PST_RUN, txn_type: PST_TXN_NONE, core_en: 1'b1, bus_en: 1'b1,
        lint_en: 1'b1, default: 1'b0};
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign save_state_req_out = ctrl_r.save_req;
  assign mgmt_exec_mode_out = ctrl_r.mgmt_mode;
  assign handler_fetch_out = ctrl_r.fetch;
  assign special_txn_req_out = ctrl_r.txn_req;
  assign special_txn_type_out = ctrl_r.txn_type;
  assign core_clk_en_out = ctrl_r.core_en;
  assign bus_unit_clk_en_out = ctrl_r.bus_en;
  assign local_interrupt_unit_clk_en_out = ctrl_r.lint_en;
  assign snoop_en_out = ctrl_r.bus_en; // R6
  assign irq_pending_out = ctrl_r.irq_pend;
  assign irq_service_out = ctrl_r.svc;
  assign exec_halt_out = ctrl_r.trip; // R9
  assign overtemp_halt_n_out = ~ctrl_r.trip; // R9 R14

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Hot with power up trips on the next edge
  property p_trip_sets;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (hot && pwr_any) |=> (!overtemp_halt_n_out && exec_halt_out && !core_clk_en_out);
  endproperty
  a_trip_sets: assert property (p_trip_sets) // R9
    else $error("trip not raised when hot");
  // Trip holds while any supply is up, even when cool
  property p_trip_holds;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!overtemp_halt_n_out && pwr_any) |=> (!overtemp_halt_n_out && $stable(ctrl_r.st));
  endproperty
  a_trip_holds: assert property (p_trip_holds) // R10
    else $error("trip released or state moved while latched");
  // Both supplies gone releases the trip
  property p_trip_release;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!pwr_any) |=> overtemp_halt_n_out;
  endproperty
  a_trip_release: assert property (p_trip_release) // R14
    else $error("trip held after supply removal");
  // Stop-grant gating
  property p_stop_gating;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_STOP) |-> (!core_clk_en_out && bus_unit_clk_en_out
        && local_interrupt_unit_clk_en_out && snoop_en_out);
  endproperty
  a_stop_gating: assert property (p_stop_gating) // R5
    else $error("wrong clock gating in stop-grant");
  // Interrupt arriving in stop-grant becomes pending
  property p_stop_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_STOP && irq_event_in) |=> irq_pending_out;
  endproperty
  a_stop_latch: assert property (p_stop_latch) // R6
    else $error("interrupt lost in stop-grant");
  // Sleep held: bus and interrupt unit clocks stay off, no new interrupt latched
  property p_sleep;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_SLEEP && sleep_req && !irq_pending_out) |=>
        (!irq_pending_out && !bus_unit_clk_en_out && !local_interrupt_unit_clk_en_out);
  endproperty
  a_sleep: assert property (p_sleep) // R16
    else $error("activity seen in sleep");
  // Sleep release goes back to stop-grant with clocks restarted
  property p_sleep_exit;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_SLEEP && !sleep_req && !ctrl_r.trip) |=>
        (ctrl_r.st == PST_STOP && bus_unit_clk_en_out && local_interrupt_unit_clk_en_out);
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) // R17
    else $error("sleep exit wrong");
  // Halt request in run issues the stop-grant acknowledge
  property p_stop_entry;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_RUN && halt_req && !ctrl_r.trip) |=>
        (special_txn_req_out && special_txn_type_out == PST_TXN_STOP_ACK
          && !core_clk_en_out);
  endproperty
  a_stop_entry: assert property (p_stop_entry) // R4
    else $error("no stop-grant acknowledge");
  // Pending management request in run starts the state save
  property p_mgmt_save;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_RUN && ctrl_r.mgmt_pend && !ctrl_r.mgmt_mode && !halt_req
        && !ctrl_r.trip) |=> (save_state_req_out && !mgmt_exec_mode_out);
  endproperty
  a_mgmt_save: assert property (p_mgmt_save) // R1
    else $error("state save not requested");
  // Save done enters the mode and raises the acknowledge, no fetch yet
  property p_mgmt_ack;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_SAVE && save_done_in && !ctrl_r.trip) |=>
        (mgmt_exec_mode_out && special_txn_req_out
          && special_txn_type_out == PST_TXN_MGMT_ACK && !handler_fetch_out);
  endproperty
  a_mgmt_ack: assert property (p_mgmt_ack) // R2
    else $error("management acknowledge not raised");
  // Acknowledge taken ends the request and starts the handler fetch
  property p_mgmt_fetch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_MGMT_ACK && special_txn_ack_in && !ctrl_r.trip) |=>
        (handler_fetch_out && !special_txn_req_out && ctrl_r.st == PST_RUN);
  endproperty
  a_mgmt_fetch: assert property (p_mgmt_fetch) // R2
    else $error("handler fetch not started after acknowledge");
  // Halt release services latched interrupts in the first cycle back in run, unless a trip cuts in
  property p_resume;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl_r.st == PST_STOP && !sleep_req && !halt_req && irq_pending_out && !ctrl_r.trip
        && !hot) ##1 !hot |=> (irq_service_out && ctrl_r.st == PST_RUN && core_clk_en_out);
  endproperty
  a_resume: assert property (p_resume) // R7
    else $error("pending interrupt not serviced on resume");

endmodule

// ---- verification/pst_sys_model.sv ----
// System logic model: request pins, supply control and bus acknowledge
`timescale 1ns/1ps
module pst_sys_model (
  // Clock
  input wire logic core_clk_in,
  // Commands from the bench
  input wire logic mgmt_cmd_in,
  input wire logic halt_cmd_in,
  input wire logic sleep_cmd_in,
  input wire logic hot_cmd_in,
  input wire logic restore_in,
  input wire logic [7:0] cut_dly_in,
  input wire logic [3:0] ack_dly_in,
  // Observed controller outputs
  input wire logic overtemp_halt_n_in,
  input wire logic special_txn_req_in,
  // Pins toward the controller
  output logic mgmt_irq_req_n_out,
  output logic clock_halt_req_n_out,
  output logic deep_sleep_req_n_out,
  output logic temp_over_trip_out,
  output logic core_pwr_good_out,
  output logic term_pwr_good_out,
  output logic special_txn_ack_out
);
  logic pwr_r = 1'b1;
  logic [7:0] cut_cnt_r = 8'h00;
  logic ack_r = 1'b0;
  logic [3:0] ack_cnt_r = 4'h0;

  // ----------------------------------------------------------------
  // Request and sensor pins skewed off the clock edge; supply and acknowledge pins are not
  // ----------------------------------------------------------------
  assign #3 mgmt_irq_req_n_out = ~mgmt_cmd_in;
  assign #3 clock_halt_req_n_out = ~halt_cmd_in;
  assign #3 deep_sleep_req_n_out = ~sleep_cmd_in;
  assign #3 temp_over_trip_out = hot_cmd_in;
  assign core_pwr_good_out = pwr_r;
  assign term_pwr_good_out = pwr_r;
  assign special_txn_ack_out = ack_r;

  // Cut both supplies after a trip; power returns only on command
  always @(posedge core_clk_in) begin
    if (restore_in) begin
      pwr_r <= 1'b1;
      cut_cnt_r <= 8'h00;
    end else if (pwr_r && !overtemp_halt_n_in) begin
      if (cut_cnt_r >= cut_dly_in) begin
        pwr_r <= 1'b0;
      end else begin
        cut_cnt_r <= cut_cnt_r + 8'h01;
      end
    end
  end

  // Acknowledge a special transaction after a set delay, one cycle wide
  always @(posedge core_clk_in) begin
    if (ack_r) begin
      ack_r <= 1'b0;
      ack_cnt_r <= 4'h0;
    end else if (special_txn_req_in && ack_cnt_r >= ack_dly_in) begin
      ack_r <= 1'b1;
    end else if (special_txn_req_in) begin
      ack_cnt_r <= ack_cnt_r + 4'h1;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the power state and thermal trip controller
`timescale 1ns/1ps
module tb_top;
  import pst_pkg::*;
  localparam int M_SAVE = 0, M_MODE = 1, M_FETCH = 2, M_TXN = 3, M_CORE = 4, M_BUS = 5;
  localparam int M_PEND = 8, M_SERV = 9, M_HALT = 10, M_TRIP_N = 11;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mgmt_cmd = 1'b0, halt_cmd = 1'b0, sleep_cmd = 1'b0, hot_cmd = 1'b0, restore = 1'b0;
  logic [7:0] cut_dly = 8'hFF;
  logic [3:0] ack_dly = 4'h2;
  logic save_done = 1'b0, mgmt_resume = 1'b0, irq_event = 1'b0;
  logic mgmt_n, halt_n, sleep_n, hot, core_pg, term_pg, ack;
  logic save, mode, fetch, txn_req, core_en, bus_en, lint_en, snoop, pend, serv, ex_halt, trip_n;
  logic [1:0] txn_type;
  logic [11:0] mon;
  int num_errors = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // Clock, monitor vector and instances
  // ----------------------------------------------------------------
  always #12.5 core_clk_in = ~core_clk_in;
  assign mon = {trip_n, ex_halt, serv, pend, snoop, lint_en, bus_en, core_en, txn_req, fetch,
                mode, save};

  pst_sys_model sys (.core_clk_in(core_clk_in), .mgmt_cmd_in(mgmt_cmd), .halt_cmd_in(halt_cmd),
    .sleep_cmd_in(sleep_cmd), .hot_cmd_in(hot_cmd), .restore_in(restore), .cut_dly_in(cut_dly),
    .ack_dly_in(ack_dly), .overtemp_halt_n_in(trip_n), .special_txn_req_in(txn_req),
    .mgmt_irq_req_n_out(mgmt_n), .clock_halt_req_n_out(halt_n), .deep_sleep_req_n_out(sleep_n),
    .temp_over_trip_out(hot), .core_pwr_good_out(core_pg), .term_pwr_good_out(term_pg),
    .special_txn_ack_out(ack));

  pst_ctrl dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mgmt_irq_req_n_in(mgmt_n),
    .clock_halt_req_n_in(halt_n), .deep_sleep_req_n_in(sleep_n), .temp_over_trip_in(hot),
    .core_pwr_good_in(core_pg), .term_pwr_good_in(term_pg), .save_done_in(save_done),
    .mgmt_resume_in(mgmt_resume), .irq_event_in(irq_event), .special_txn_ack_in(ack),
    .save_state_req_out(save), .mgmt_exec_mode_out(mode), .handler_fetch_out(fetch),
    .special_txn_req_out(txn_req), .special_txn_type_out(txn_type), .core_clk_en_out(core_en),
    .bus_unit_clk_en_out(bus_en), .local_interrupt_unit_clk_en_out(lint_en),
    .snoop_en_out(snoop), .irq_pending_out(pend), .irq_service_out(serv),
    .exec_halt_out(ex_halt), .overtemp_halt_n_out(trip_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected {snoop, interrupt unit, bus, core} enables: 0 run, 1 stop-grant, 2 sleep
  function automatic logic [7:0] en_exp(input int pm);
    case (pm)
      0: return 8'h0F;
      1: return 8'h0E;
      default: return 8'h00;
    endcase
  endfunction

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // Bounded wait on one monitored output; running out ends the run
  task automatic wait_mon(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (mon[idx] !== val && n < lim) begin
      cyc(1);
      n++;
    end
    chk({7'h00, mon[idx]}, {7'h00, val});
    if (mon[idx] !== val) wrap_up();
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    cyc(4);
    rst_n_in = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int unsigned seed;
    seed = $urandom(67);
    do_reset();
    chk({4'h0, mon[7:4]}, en_exp(0));
    chk({7'h00, trip_n}, 8'h01);
    $display("Test reset done");
    // Management entry with random save and acknowledge delays
    for (i = 0; i < 3; i++) begin
      ack_dly = 4'($urandom_range(0, 7));
      mgmt_cmd = 1'b1;
      wait_mon(M_SAVE, 1'b1, 10);
      chk({7'h00, mode}, 8'h00);
      cyc($urandom_range(0, 4));
      save_done = 1'b1;
      cyc(1);
      save_done = 1'b0;
      wait_mon(M_MODE, 1'b1, 4);
      chk({6'h00, txn_type}, {6'h00, PST_TXN_MGMT_ACK});
      chk({7'h00, fetch}, 8'h00);
      wait_mon(M_FETCH, 1'b1, 20);
      chk({7'h00, txn_req}, 8'h00);
      mgmt_cmd = 1'b0;
      mgmt_resume = 1'b1;
      cyc(1);
      mgmt_resume = 1'b0;
      cyc(4);
    end
    $display("Test management done");
    // Stop-grant, interrupt latching, sleep and resume
    ack_dly = 4'h3;
    halt_cmd = 1'b1;
    wait_mon(M_TXN, 1'b1, 10);
    chk({6'h00, txn_type}, {6'h00, PST_TXN_STOP_ACK});
    wait_mon(M_TXN, 1'b0, 20);
    chk({4'h0, mon[7:4]}, en_exp(1));
    // Sleep first: an interrupt arriving there must not latch
    sleep_cmd = 1'b1;
    wait_mon(M_BUS, 1'b0, 10);
    chk({4'h0, mon[7:4]}, en_exp(2));
    irq_event = 1'b1;
    cyc(1);
    irq_event = 1'b0;
    cyc(1);
    chk({7'h00, pend}, 8'h00);
    sleep_cmd = 1'b0;
    wait_mon(M_BUS, 1'b1, 10);
    chk({4'h0, mon[7:4]}, en_exp(1));
    // Back in stop-grant an interrupt latches and stays pending
    irq_event = 1'b1;
    cyc(1);
    irq_event = 1'b0;
    chk({7'h00, pend}, 8'h01);
    halt_cmd = 1'b0;
    wait_mon(M_CORE, 1'b1, 10);
    wait_mon(M_SERV, 1'b1, 3);
    cyc(1);
    chk({7'h00, pend}, 8'h00);
    $display("Test stop-grant done");
    // Trip re-asserted after reset while hot, cleared by reset once cool
    cut_dly = 8'hFF;
    hot_cmd = 1'b1;
    wait_mon(M_TRIP_N, 1'b0, 5);
    do_reset();
    wait_mon(M_TRIP_N, 1'b0, 5);
    chk({7'h00, ex_halt}, 8'h01);
    hot_cmd = 1'b0;
    do_reset();
    cyc(4);
    chk({7'h00, trip_n}, 8'h01);
    chk({4'h0, mon[7:4]}, en_exp(0));
    restore = 1'b1;
    cyc(1);
    restore = 1'b0;
    // Trip latched until both supplies are cut, random cut delays
    for (i = 0; i < 3; i++) begin
      cut_dly = 8'($urandom_range(5, 60));
      cyc($urandom_range(1, 9));
      hot_cmd = 1'b1;
      wait_mon(M_TRIP_N, 1'b0, 5);
      chk({7'h00, ex_halt}, 8'h01);
      chk({7'h00, core_en}, 8'h00);
      hot_cmd = i[0];
      cyc(3);
      chk({7'h00, trip_n}, 8'h00);
      wait_mon(M_TRIP_N, 1'b1, 80);
      hot_cmd = 1'b0;
      restore = 1'b1;
      cyc(1);
      restore = 1'b0;
      do_reset();
      cyc(4);
      chk({7'h00, ex_halt}, 8'h00);
    end
    $display("Test thermal trip done");
    wrap_up();
  end
endmodule
